// [src/ctc_pkg.sv]
// What this block does
// R1 - Gated mode: conversion length comes from the external gate pin.
// R2 - Window count enable set: count internal clocks in window, readable.
// R3 - Window clock counter holds counts up to 24 bits.
// R4 - Window count enable set in gated mode: temperature values also produced.
// R5 - Enable clear in gated mode: no counting, no temperature, result invalid; code still writes the result and sets done.
// R6 - Prescaler enable: 0 bypasses divider, 1 applies it.
// R7 - Prescaler exponent ignored unless prescaler enable is 1.
// R8 - Exponent field bits 2:0 divides by two to the power one plus field.
// R9 - Divider extends range of 16-bit results at reduced resolution.
// R10 - Result counter overflow sets the result overflow flag.
// R11 - Host should enable divider for long times and gated mode.
// R12 - Gated mode selected by measurement mode code 11.
// R13 - Gated conversion ends after programmed further falling gate edges.
// R14 - Bits 7, 5, 4 of config_two reserved: read zero, writes ignored.
package ctc_pkg;
  localparam logic [3:0] CTC_ADDR_CONFIG_TWO = 4'h7;
  localparam logic [3:0] CTC_ADDR_MODE = 4'h8;
  localparam logic [3:0] CTC_ADDR_EDGES = 4'h9;
  localparam logic [3:0] CTC_ADDR_COUNT = 4'hA;
  localparam logic [3:0] CTC_ADDR_RESULT = 4'hB;
  localparam logic [3:0] CTC_ADDR_TEMP = 4'hC;
  localparam logic [3:0] CTC_ADDR_STATUS = 4'hD;
  localparam logic [3:0] CTC_ADDR_MASK = 4'hE;
  localparam int CTC_BIT_WCE = 6;
  localparam int CTC_BIT_PSE = 3;
  localparam int CTC_DIV_HI = 2;
  localparam logic [7:0] CTC_CFG2_WMASK = 8'h4F;
  localparam logic [7:0] CTC_CFG2_RESET = 8'h40;
  localparam logic [1:0] CTC_MODE_RESET = 2'h1;
  localparam logic [1:0] CTC_MODE_GATED = 2'h3;
  localparam logic [7:0] CTC_EDGES_RESET = 8'h01;
  localparam int CTC_CNT_W = 24;
  localparam int CTC_RES_W = 16;
  localparam int CTC_ST_DONE = 0;
  localparam int CTC_ST_OVF = 1;
  localparam int CTC_ST_TVALID = 2;
  localparam logic [2:0] CTC_ST_RESET = 3'h0;
  localparam logic [2:0] CTC_MASK_RESET = 3'h0;
  typedef enum logic [1:0] {
    CTC_IDLE = 2'b00,
    CTC_ARM = 2'b01,
    CTC_RUN = 2'b10
  } ctc_state_t;
endpackage

// [src/ctc_gate_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface ctc_gate_if;
  logic fall;
  modport src (output fall);
  modport dst (input fall);
endinterface
`default_nettype wire

// [src/ctc_gate_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module ctc_gate_sync
  import ctc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pin
  input wire logic pin,
  // Edge event
  ctc_gate_if.src ev
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ctc_sync_t;
  ctc_sync_t q, next_q;
  always_comb begin
    next_q = q;
    next_q.s1 = pin;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
    end else begin
      q <= next_q;
    end
  end
  assign ev.fall = q.s3 & ~q.s2;
endmodule
`default_nettype wire

// [src/ctc_top.sv]
`timescale 1ns/10ps
`default_nettype none
module ctc_top
  import ctc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Sensor side
  input wire logic external_gate_pin,
  input wire logic [15:0] temp_sample,
  output logic temp_measure_en,
  output logic conv_active,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    logic [7:0] config_two;
    logic [1:0] measure_mode_select;
    logic [7:0] edges;
    ctc_state_t st;
    logic [7:0] edge_left;
    logic [CTC_CNT_W-1:0] cnt;
    logic [CTC_CNT_W-1:0] clock_count_result;
    logic [CTC_CNT_W:0] res_acc;
    logic [CTC_RES_W-1:0] result;
    logic [CTC_RES_W-1:0] temp;
    logic [2:0] status;
    logic [2:0] mask;
    logic ack;
    logic err;
    logic [31:0] rdata;
  } ctc_regs_t;

  ctc_regs_t q, next_q;
  ctc_gate_if gate();

  ctc_gate_sync ctc_gate_sync_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(external_gate_pin),
    .ev(gate.src)
  );

  logic req;
  logic wr;
  logic [3:0] idx;
  logic gated;
  logic wce;
  logic div_on;
  logic [3:0] shift;
  logic [CTC_CNT_W:0] scaled;
  logic ovf_ev;
  logic done_ev;
  logic tv_ev;
  logic [2:0] st_set;
  logic [2:0] w1c;
  logic [7:0] wbyte;

  assign req = wb_cyc_i & wb_stb_i & ~q.ack & ~q.err;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[5:2];
  assign wbyte = wb_dat_i[7:0];
  assign gated = (q.measure_mode_select == CTC_MODE_GATED); // [R12]
  assign wce = q.config_two[CTC_BIT_WCE];
  assign div_on = q.config_two[CTC_BIT_PSE]; // [R6]
  // Exponent only counts when divider on
  assign shift = div_on ? ({1'b0, q.config_two[CTC_DIV_HI:0]} + 4'h1)
                        : 4'h0; // [R7] [R8]
  assign scaled = q.res_acc >> shift; // [R9]

  always_comb begin
    next_q = q;
    ovf_ev = 1'b0;
    done_ev = 1'b0;
    tv_ev = 1'b0;
    w1c = 3'h0;
    next_q.ack = req & ~wb_err_o;
    next_q.err = 1'b0;
    next_q.rdata = 32'h0000_0000;
    if (req) begin
      case (idx)
        CTC_ADDR_CONFIG_TWO: begin
          next_q.rdata = {24'h00_0000, q.config_two};
          if (wr) begin
            next_q.config_two = wbyte & CTC_CFG2_WMASK; // [R14]
          end
        end
        CTC_ADDR_MODE: begin
          next_q.rdata = {30'h0, q.measure_mode_select};
          if (wr) begin
            next_q.measure_mode_select = wbyte[1:0];
          end
        end
        CTC_ADDR_EDGES: begin
          next_q.rdata = {24'h00_0000, q.edges};
          if (wr) begin
            next_q.edges = (wbyte == 8'h00) ? CTC_EDGES_RESET : wbyte;
          end
        end
        CTC_ADDR_COUNT: begin
          next_q.rdata = {8'h00, q.clock_count_result}; // [R2]
        end
        CTC_ADDR_RESULT: begin
          next_q.rdata = {16'h0000, q.result};
        end
        CTC_ADDR_TEMP: begin
          next_q.rdata = {16'h0000, q.temp};
        end
        CTC_ADDR_STATUS: begin
          next_q.rdata = {29'h0, q.status};
          if (wr) begin
            w1c = wbyte[2:0];
          end
        end
        CTC_ADDR_MASK: begin
          next_q.rdata = {29'h0, q.mask};
          if (wr) begin
            next_q.mask = wbyte[2:0];
          end
        end
        default: begin
          next_q.ack = 1'b0;
          next_q.err = 1'b1;
        end
      endcase
    end

    case (q.st)
      CTC_IDLE: begin
        if (gated && gate.fall) begin // [R1]
          next_q.st = CTC_RUN;
          next_q.edge_left = q.edges;
          // First clock of the window counts at the start edge
          next_q.cnt = {{(CTC_CNT_W-1){1'b0}}, wce}; // [R2]
          next_q.res_acc = {{CTC_CNT_W{1'b0}}, 1'b1};
        end
      end
      CTC_RUN: begin
        // Window clock count only when enabled
        if (wce && q.cnt != {CTC_CNT_W{1'b1}}) begin
          next_q.cnt = q.cnt + 24'h00_0001; // [R2] [R3]
        end
        if (q.res_acc[CTC_CNT_W] == 1'b0) begin
          next_q.res_acc = q.res_acc + 25'h000_0001;
        end
        if (!gated) begin
          next_q.st = CTC_IDLE;
        end else if (gate.fall) begin
          if (q.edge_left <= 8'h01) begin // [R13]
            next_q.st = CTC_IDLE;
            done_ev = 1'b1;
          end else begin
            next_q.edge_left = q.edge_left - 8'h01;
          end
        end
      end
      default: begin
        next_q.st = CTC_IDLE;
      end
    endcase

    if (done_ev) begin
      if (scaled[CTC_CNT_W:CTC_RES_W] != '0) begin
        ovf_ev = 1'b1; // [R10]
        next_q.result = {CTC_RES_W{1'b1}};
      end else begin
        next_q.result = scaled[CTC_RES_W-1:0];
      end
      if (wce) begin
        next_q.clock_count_result = q.cnt; // [R2]
        next_q.temp = temp_sample; // [R4]
        tv_ev = 1'b1;
      end
    end

    st_set = 3'h0;
    st_set[CTC_ST_DONE] = done_ev;
    st_set[CTC_ST_OVF] = ovf_ev;
    st_set[CTC_ST_TVALID] = tv_ev;
    // Set wins over clear
    next_q.status = (q.status & ~w1c) | st_set;
    // Temperature invalid when counting off in gated mode
    if (gated && !wce) begin
      next_q.status[CTC_ST_TVALID] = 1'b0; // [R5]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
      q.config_two <= CTC_CFG2_RESET;
      q.measure_mode_select <= CTC_MODE_RESET;
      q.edges <= CTC_EDGES_RESET;
      q.st <= CTC_IDLE;
      q.status <= CTC_ST_RESET;
      q.mask <= CTC_MASK_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign wb_err_o = q.err;
  assign temp_measure_en = (q.st == CTC_RUN) & wce; // [R4] [R5]
  assign conv_active = (q.st == CTC_RUN);
  assign irq = |(q.status & q.mask);
endmodule
`default_nettype wire

// [verif/ctc_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module ctc_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Sensor and interrupt
  input wire logic external_gate_pin,
  input wire logic temp_measure_en,
  input wire logic conv_active,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic req;
  logic bad;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign bad = wb_adr_i[5:2] < 4'h7 || wb_adr_i[5:2] > 4'hE;
  bus_answer_a: assert property (req |=> wb_ack_o || wb_err_o)
    else $error("request not answered");
  unmapped_err_a: assert property (
    req && bad |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  one_answer_a: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  temp_in_conv_a: assert property (temp_measure_en |-> conv_active)
    else $error("temperature outside conversion");
  gate_start_a: assert property (
    $rose(conv_active) |-> !$past(external_gate_pin))
    else $error("conversion start without gate fall");
  reset_quiet_a: assert property (
    $rose(rst_n) |-> !irq && !conv_active)
    else $error("outputs busy after reset");
  cover property ($rose(conv_active));
  cover property ($rose(irq));
  cover property (wb_err_o);
endmodule
bind ctc_top ctc_properties ctc_properties_i (.mclk, .rst_n, .wb_cyc_i,
  .wb_stb_i, .wb_adr_i, .wb_ack_o, .wb_err_o, .external_gate_pin,
  .temp_measure_en, .conv_active, .irq);
`default_nettype wire

// [verif/ctc_gate_src.sv]
`timescale 1ns/10ps
`default_nettype none
module ctc_gate_src (
  // Clock
  input wire logic mclk,
  // Gate pin
  output var logic pin
);
  initial pin = 1'b1;
  // One fall, next fall p cycles later
  task automatic gate(input int p);
    pin <= 1'b0;
    repeat (4) @(posedge mclk);
    pin <= 1'b1;
    repeat (p - 4) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// [verif/ctc_top_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module ctc_top_bench;
  import ctc_pkg::*;
  logic mclk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [5:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic wb_ack_o, wb_err_o, gate, temp_measure_en, conv_active, irq, err;
  logic msk = 0;
  int failures = 0, checks_done = 0;
  always #5 mclk = ~mclk;
  ctc_gate_src ctc_gate_src_i (.mclk, .pin(gate));
  ctc_top ctc_top_i (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .external_gate_pin(gate), .temp_sample(16'h1234), .temp_measure_en,
    .conv_active, .irq);
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic [3:0] i, input logic w, input logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= d;
    do begin
      @(posedge mclk);
    end while (!(wb_ack_o || wb_err_o));
    q = wb_dat_o;
    err = wb_err_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    wb(i, 1, d);
  endtask
  task automatic rc(input string nm, input logic [3:0] i, logic [31:0] e);
    wb(i, 0, '0);
    chk(nm, q, e);
  endtask
  task automatic run(input logic [7:0] c, input int p, logic [31:0] r, st);
    wr(CTC_ADDR_STATUS, 7);
    wr(CTC_ADDR_CONFIG_TWO, 32'(c));
    ctc_gate_src_i.gate(p);
    chk("busy", 32'({conv_active, temp_measure_en}),
      32'({1'b1, c[6]}));
    ctc_gate_src_i.gate(8);
    if (c[6]) rc("result", CTC_ADDR_RESULT, r);
    rc("status", CTC_ADDR_STATUS, st);
    chk("irq", 32'(irq), 32'(msk));
  endtask
  task automatic report_and_stop;
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge mclk);
    failures++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    rc("cfg2", CTC_ADDR_CONFIG_TWO, 32'h0000_0040);
    wr(CTC_ADDR_CONFIG_TWO, 32'h0000_00FF);
    rc("cfg2", CTC_ADDR_CONFIG_TWO, 32'h0000_004F);
    wb(4'h0, 1, '0);
    chk("err", 32'(err), 1);
    wr(CTC_ADDR_EDGES, 0);
    rc("edges", CTC_ADDR_EDGES, 1);
    ctc_gate_src_i.gate(20);
    ctc_gate_src_i.gate(8);
    rc("status", CTC_ADDR_STATUS, 0);
    wr(CTC_ADDR_MODE, 32'(CTC_MODE_GATED));
    wr(CTC_ADDR_MASK, 1);
    msk = 1;
    run(8'h40, 40, 40, 5);
    rc("count", CTC_ADDR_COUNT, 40);
    rc("temp", CTC_ADDR_TEMP, 32'h0000_1234);
    for (int e = 0; e < 8; e++) begin
      run(8'h48 | 8'(e), 40, 40 >> (e + 1), 5);
    end
    run(8'h47, 40, 40, 5);
    run(8'h00, 40, 0, 1);
    run(8'h40, 70000, 32'h0000_FFFF, 7);
    rc("count", CTC_ADDR_COUNT, 70000);
    wr(CTC_ADDR_MASK, 0);
    msk = 0;
    run(8'h40, 40, 40, 5);
    wr(CTC_ADDR_STATUS, 7);
    rc("status", CTC_ADDR_STATUS, 0);
    report_and_stop;
  end
endmodule
`default_nettype wire
